// *** inc/csf_consts.svh ***
// offsets, field positions, reset values and sizes of the contactless status block
//------------------------------------------------------------------------------
// How it works
// [RULE_01] Bit 7 is high while any group-one source is pending and enabled.
// [RULE_02] Firmware sets CPU enable bit two before group one can interrupt the CPU.
// [RULE_03] Bit 4 is high while any group-zero source is pending and enabled.
// [RULE_04] Firmware sets CPU enable bit three before group zero can interrupt the CPU.
// [RULE_05] Bit 6 is set when the checksum coprocessor result equals zero.
// [RULE_06] Checksum-zero bit means nothing during frame transfer; use the fail flag instead.
// [RULE_07] Checksum-zero bit is cleared during calculation, set on a correct completion.
// [RULE_08] Bit 5 is set when a compute-checksum command calculation has finished.
// [RULE_09] Bit 3 is high while the countdown timer is running.
// [RULE_10] In gated mode bit 3 follows only the enable bits, never the gate.
// [RULE_11] Bit 2 follows the field detector live, unlatched; reset value undefined. Code: three flops of lag, resets to 0.
// [RULE_12] Bit 1 is high while 64 minus fill count is at most the threshold.
// [RULE_13] Bit 0 is high while the fill count is at most the threshold.
// [RULE_14] Writes to the status register are ignored; reads change no flag.
//------------------------------------------------------------------------------
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// register index as printed; byte address is four times it
`define CSF_STATUS_ONE_IDX  10'h0DF
`define CSF_STATUS_ONE_ADDR {`CSF_STATUS_ONE_IDX, 2'b00}
`define CSF_IRQ_STAT_ADDR   12'h000
`define CSF_IRQ_MASK_ADDR   12'h004
`define CSF_THRESH_ADDR     12'h008

`define CSF_BIT_GRP1        7
`define CSF_BIT_CRC_ZERO    6
`define CSF_BIT_CRC_DONE    5
`define CSF_BIT_GRP0        4
`define CSF_BIT_COUNTDOWN   3
`define CSF_BIT_FIELD       2
`define CSF_BIT_NEAR_FULL   1
`define CSF_BIT_NEAR_EMPTY  0

`define CSF_STATUS_ONE_RST  8'h21
`define CSF_IRQ_MASK_RST    6'h00
`define CSF_THRESH_RST      6'h08
`define CSF_FIFO_DEPTH      7'h40
`define CSF_EVENT_COUNT     6

`endif

// *** inc/csf_pkg.sv ***
// types shared by the contactless status block
package csf_pkg;

  typedef struct packed {
    logic [7:0] pending;
    logic [7:0] enable;
  } csf_irq_grp_s;

  typedef struct packed {
    logic busy;
    logic result_zero;
    logic done;
    logic cmd_start;
    logic cmd_done;
    logic frame_active;
  } csf_crc_s;

  typedef struct packed {
    logic [6:0] fill_count;
  } csf_fifo_s;

  typedef enum logic {
    CSF_BUS_IDLE,
    CSF_BUS_DATA
  } csf_bus_e;

  typedef struct packed {
    logic        wr_en;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csf_reg_req_s;

endpackage

// *** src/csf_ahb_slave.sv ***
// AHB-Lite slave with one wait state for the contactless status registers
`timescale 1ns/100ps
module csf_ahb_slave (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // register side
  output csf_pkg::csf_reg_req_s     reg_req,
  input  wire logic [31:0]          rd_data
);
  import csf_pkg::*;

  typedef struct packed {
    csf_bus_e    phase;
    logic        write;
    logic [11:0] addr;
    logic        ready;
    logic [31:0] rdata;
  } csf_bus_state_s;

  csf_bus_state_s s;
  csf_bus_state_s next_s;

  //----------------------------------------------------------------------------
  // transfer sequencing
  //----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    case (s.phase)
      CSF_BUS_IDLE: begin
        if (hsel && hready && htrans[1]) begin
          next_s.phase = CSF_BUS_DATA;
          next_s.write = hwrite;
          next_s.addr  = haddr[11:0];
          next_s.ready = 1'b0;
        end
      end
      CSF_BUS_DATA: begin
        next_s.phase = CSF_BUS_IDLE;
        next_s.ready = 1'b1;
        if (!s.write) begin
          next_s.rdata = rd_data;
        end
      end
      default: begin
        next_s.phase = CSF_BUS_IDLE;
        next_s.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{phase: CSF_BUS_IDLE, write: 1'b0, addr: 12'h000, ready: 1'b1,
             rdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  // write lands at the end of the stalled data-phase cycle, when hwdata stands
  assign reg_req       = '{wr_en: (s.phase == CSF_BUS_DATA) && s.write,
                           addr:  s.addr,
                           wdata: hwdata};
  assign hreadyout     = s.ready;
  assign hrdata        = s.rdata;
  assign hresp         = 1'b0;

endmodule

// *** src/csf_status_top.sv ***
// contactless status flags register block with event interrupt
`timescale 1ns/100ps
`include "csf_consts.svh"
module csf_status_top (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // interrupt sources of both groups
  input  csf_pkg::csf_irq_grp_s     attention_group_one,
  input  csf_pkg::csf_irq_grp_s     attention_group_zero,
  // checksum coprocessor
  input  csf_pkg::csf_crc_s         checksum,
  // countdown timer register enable bits
  input  wire logic                 countdown_enabled,
  // field detector pin
  input  wire logic                 rf_field_detect,
  // fifo
  input  csf_pkg::csf_fifo_s        fifo,
  // status and interrupt
  output logic [7:0]                contactless_status_one,
  output logic                      irq
);
  import csf_pkg::*;

  typedef struct packed {
    logic        field_meta;
    logic        field_sync;
    logic [7:0]  status;
    logic [5:0]  irq_stat;
    logic [5:0]  irq_mask;
    logic [5:0]  fifo_threshold;
    logic        irq;
  } csf_state_s;

  csf_state_s    s;
  csf_state_s    next_s;
  csf_reg_req_s  reg_req;
  logic [31:0]   rd_data;
  logic          grp1;
  logic          grp0;
  logic          near_full;
  logic          near_empty;
  logic [5:0]    events;
  logic [5:0]    clr_bits;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  function automatic logic group_active(input csf_irq_grp_s g);
    group_active = |(g.pending & g.enable);
  endfunction

  function automatic logic [5:0] event_bits(input logic [7:0] st);
    event_bits = {st[`CSF_BIT_GRP1], st[`CSF_BIT_CRC_DONE], st[`CSF_BIT_GRP0],
                  st[`CSF_BIT_FIELD], st[`CSF_BIT_NEAR_FULL], st[`CSF_BIT_NEAR_EMPTY]};
  endfunction

  //----------------------------------------------------------------------------
  // bus slave
  //----------------------------------------------------------------------------
  csf_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .reg_req   (reg_req),
    .rd_data   (rd_data)
  );

  // reads have no side effect; unmapped addresses read zero
  always_comb begin
    case (reg_req.addr)
      `CSF_STATUS_ONE_ADDR: rd_data = {24'h00_0000, s.status}; // RULE_14
      `CSF_IRQ_STAT_ADDR:   rd_data = {26'h000_0000, s.irq_stat};
      `CSF_IRQ_MASK_ADDR:   rd_data = {26'h000_0000, s.irq_mask};
      `CSF_THRESH_ADDR:     rd_data = {26'h000_0000, s.fifo_threshold};
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  //----------------------------------------------------------------------------
  // flag derivation
  //----------------------------------------------------------------------------
  assign grp1       = group_active(attention_group_one);  // RULE_01
  assign grp0       = group_active(attention_group_zero); // RULE_03
  assign near_full  = (`CSF_FIFO_DEPTH - fifo.fill_count) <= {1'b0, s.fifo_threshold}; // RULE_12
  assign near_empty = fifo.fill_count <= {1'b0, s.fifo_threshold}; // RULE_13

  always_comb begin
    next_s = s;
    next_s.field_meta = rf_field_detect;
    next_s.field_sync = s.field_meta;

    next_s.status[`CSF_BIT_GRP1]       = grp1;               // RULE_01
    next_s.status[`CSF_BIT_GRP0]       = grp0;               // RULE_03
    // gate input deliberately not used
    next_s.status[`CSF_BIT_COUNTDOWN]  = countdown_enabled;  // RULE_09 RULE_10
    next_s.status[`CSF_BIT_FIELD]      = s.field_sync;       // RULE_11
    next_s.status[`CSF_BIT_NEAR_FULL]  = near_full;          // RULE_12
    next_s.status[`CSF_BIT_NEAR_EMPTY] = near_empty;         // RULE_13

    // frame traffic leaves the zero flag untouched
    if (!checksum.frame_active) begin                        // RULE_06
      if (checksum.busy) begin
        next_s.status[`CSF_BIT_CRC_ZERO] = 1'b0;             // RULE_07
      end else if (checksum.done) begin
        next_s.status[`CSF_BIT_CRC_ZERO] = checksum.result_zero; // RULE_05 RULE_07
      end
    end

    // command finish wins over a new command start
    if (checksum.cmd_done) begin
      next_s.status[`CSF_BIT_CRC_DONE] = 1'b1;               // RULE_08
    end else if (checksum.cmd_start) begin
      next_s.status[`CSF_BIT_CRC_DONE] = 1'b0;               // RULE_08
    end

    // register writes; status_one is not writable
    clr_bits = 6'h00;
    if (reg_req.wr_en) begin                                 // RULE_14
      case (reg_req.addr)
        `CSF_IRQ_STAT_ADDR: clr_bits              = reg_req.wdata[5:0];
        `CSF_IRQ_MASK_ADDR: next_s.irq_mask       = reg_req.wdata[5:0];
        `CSF_THRESH_ADDR:   next_s.fifo_threshold = reg_req.wdata[5:0];
        default: ;
      endcase
    end

    // rising flags other than checksum zero and countdown are sticky events; a new event beats a clear
    events          = event_bits(next_s.status) & ~event_bits(s.status);
    next_s.irq_stat = (s.irq_stat & ~clr_bits) | events;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{field_meta: 1'b0, field_sync: 1'b0, status: `CSF_STATUS_ONE_RST,
             irq_stat: 6'h00, irq_mask: `CSF_IRQ_MASK_RST,
             fifo_threshold: `CSF_THRESH_RST, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign contactless_status_one = s.status;
  assign irq                    = s.irq;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  group_one_flag_a: assert property ( // RULE_01
    1'b1 |=> (contactless_status_one[`CSF_BIT_GRP1] == $past(grp1)))
    else $error("group one flag does not follow pending and enabled sources");

  group_zero_flag_a: assert property ( // RULE_03
    1'b1 |=> (contactless_status_one[`CSF_BIT_GRP0] == $past(grp0)))
    else $error("group zero flag does not follow pending and enabled sources");

  crc_zero_set_a: assert property ( // RULE_05
    (!checksum.frame_active && !checksum.busy && checksum.done && checksum.result_zero)
      |=> contactless_status_one[`CSF_BIT_CRC_ZERO])
    else $error("checksum zero flag not set on zero result");

  crc_busy_clear_a: assert property ( // RULE_07
    (!checksum.frame_active && checksum.busy)
      |=> !contactless_status_one[`CSF_BIT_CRC_ZERO])
    else $error("checksum zero flag not cleared during calculation");

  crc_frame_hold_a: assert property ( // RULE_06
    checksum.frame_active |=> $stable(contactless_status_one[`CSF_BIT_CRC_ZERO]))
    else $error("checksum zero flag moved during frame traffic");

  crc_done_set_a: assert property ( // RULE_08
    checksum.cmd_done |=> contactless_status_one[`CSF_BIT_CRC_DONE])
    else $error("checksum done flag not set after command finished");

  countdown_flag_a: assert property ( // RULE_09
    1'b1 |=> (contactless_status_one[`CSF_BIT_COUNTDOWN] == $past(countdown_enabled)))
    else $error("countdown flag does not follow the enable bits");

  field_follow_a: assert property ( // RULE_11
    rf_field_detect [*3] |=> contactless_status_one[`CSF_BIT_FIELD])
    else $error("field flag not high three cycles after detector rose");

  near_full_calc_a: assert property ( // RULE_12
    1'b1 |=> (contactless_status_one[`CSF_BIT_NEAR_FULL] == $past(near_full)))
    else $error("nearly full flag wrong for fill count and threshold");

  near_empty_calc_a: assert property ( // RULE_13
    1'b1 |=> (contactless_status_one[`CSF_BIT_NEAR_EMPTY] == $past(near_empty)))
    else $error("nearly empty flag wrong for fill count and threshold");

  status_write_ignored_a: assert property ( // RULE_14
    (reg_req.wr_en && reg_req.addr == `CSF_STATUS_ONE_ADDR)
      |=> ($stable(s.irq_mask) && $stable(s.fifo_threshold)))
    else $error("write to status register changed another register");

  irq_output_a: assert property (
    irq == |(s.irq_stat & s.irq_mask))
    else $error("interrupt output disagrees with masked status");

  group_one_cov: cover property (!grp1 ##1 grp1 ##1 contactless_status_one[`CSF_BIT_GRP1]);
  crc_cmd_cov:   cover property (checksum.cmd_start ##[1:20] checksum.cmd_done);
  near_full_cov: cover property (contactless_status_one[`CSF_BIT_NEAR_FULL]);
  irq_cov:       cover property ($rose(irq));

endmodule

// *** dv/tb.sv ***
// self-checking testbench for the contactless status flags block
`timescale 1ns/100ps
`include "csf_consts.svh"
module tb;
  import csf_pkg::*;
  //----------------------------------------------------------------------------
  // signals
  //----------------------------------------------------------------------------
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, cnt_en, rf, irq;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [7:0]   status, e;
  csf_irq_grp_s g1, g0;
  csf_crc_s     crc;
  csf_fifo_s    fifo;
  logic         z, d, old_rf, rf_d2;
  logic [5:0]   thr;
  int           errors, n_tests;
  int           seed = 32'h4e2746b5;

  csf_status_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .attention_group_one(g1),
    .attention_group_zero(g0), .checksum(crc), .countdown_enabled(cnt_en),
    .rf_field_detect(rf), .fifo(fifo), .contactless_status_one(status), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  //----------------------------------------------------------------------------
  // checking and bus tasks
  //----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ready is judged at the falling edge, so the next rising edge samples it
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      errors++;
      $display("Error at %0t: bus wait timed out", $time);
      complete_run();
    end
  endtask

  // entered right after a rising edge, leaves right after one
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_ready();
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    chk(hresp, 1'b0, "bus response");
    @(posedge hclk);
  endtask

  //----------------------------------------------------------------------------
  // expectation
  //----------------------------------------------------------------------------
  function automatic logic [7:0] exp_flags(logic zz, logic dd, logic prf);
    exp_flags = {|(g1.pending & g1.enable), zz, dd, |(g0.pending & g0.enable), cnt_en, prf,
                 (7'd64 - fifo.fill_count) <= {1'b0, thr}, fifo.fill_count <= {1'b0, thr}};
  endfunction

  task automatic update_crc;
    if (crc.busy && !crc.frame_active) z = 1'b0;
    else if (crc.done && !crc.frame_active) z = crc.result_zero;
    if (crc.cmd_done) d = 1'b1;
    else if (crc.cmd_start) d = 1'b0;
  endtask

  task automatic irq_step(input logic [31:0] m);
    bus(1'b1, `CSF_IRQ_MASK_ADDR, m, rd);
    fifo <= 7'd64;
    repeat (2) @(posedge hclk);
    bus(1'b1, `CSF_IRQ_STAT_ADDR, 32'h0000003F, rd);
    fifo <= 7'd0;
    @(posedge hclk);
    @(negedge hclk);
    chk(irq, m[0], "irq on empty event");
    @(posedge hclk);
    bus(1'b0, `CSF_IRQ_STAT_ADDR, 32'h0, rd);
    chk(rd, 32'h00000001, "event status");
    bus(1'b1, `CSF_IRQ_STAT_ADDR, 32'h00000001, rd);
    @(negedge hclk);
    chk(irq, 1'b0, "irq after clear");
    @(posedge hclk);
  endtask

  initial begin
    #500000;
    errors++;
    $display("Error at %0t: run timed out", $time);
    complete_run();
  end

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    g1 = '0;
    g0 = '0;
    crc = '0;
    cnt_en = 1'b0;
    rf = 1'b0;
    fifo = '0;
    errors = 0;
    n_tests = 0;
    z = 1'b0;
    d = 1'b1;
    thr = 6'h08;
    repeat (16) @(posedge hclk);
    @(negedge hclk);
    chk(status, 8'h21, "status reset");
    chk(irq, 1'b0, "irq reset");
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `CSF_THRESH_ADDR, 32'h0, rd);
    chk(rd, 32'h00000008, "threshold reset");
    bus(1'b0, `CSF_IRQ_MASK_ADDR, 32'h0, rd);
    chk(rd, 32'h0, "mask reset");
    $display("reset test done");
    for (int b = 0; b < 8; b++) begin
      thr = (b == 0) ? 6'h00 : (b == 1) ? 6'h3F : (b == 2) ? 6'h04 : 6'($random(seed));
      bus(1'b1, `CSF_THRESH_ADDR, {26'h0, thr}, rd);
      old_rf = rf;
      for (int i = 0; i < 40; i++) begin
        // field flag lags the pin by two sync stages and the status flop
        rf_d2  = old_rf;
        old_rf = rf;
        g1     <= csf_irq_grp_s'($random(seed));
        g0     <= csf_irq_grp_s'($random(seed));
        crc    <= csf_crc_s'($random(seed));
        cnt_en <= 1'($random(seed));
        rf     <= 1'($random(seed));
        case (i % 8)
          0:       fifo <= 7'(thr);
          1:       fifo <= 7'(thr) + 7'd1;
          4:       fifo <= 7'd64 - 7'(thr);
          5:       fifo <= 7'd63 - 7'(thr);
          default: fifo <= 7'($unsigned($random(seed)) % 65);
        endcase
        @(posedge hclk);
        update_crc();
        @(negedge hclk);
        e = exp_flags(z, d, rf_d2);
        chk(status[7], e[7], "group one");
        chk(status[6], e[6], "checksum zero");
        chk(status[5], e[5], "checksum done");
        chk(status[4], e[4], "group zero");
        chk(status[3], e[3], "countdown");
        chk(status[2], e[2], "field");
        chk(status[1], e[1], "nearly full");
        chk(status[0], e[0], "nearly empty");
      end
      @(posedge hclk);
      bus(1'b0, `CSF_STATUS_ONE_ADDR, 32'h0, rd);
      chk(rd, {24'h0, exp_flags(z, d, rf)}, "status read");
      bus(1'b1, `CSF_STATUS_ONE_ADDR, $random(seed), rd);
      bus(1'b0, `CSF_STATUS_ONE_ADDR, 32'h0, rd);
      chk(rd, {24'h0, exp_flags(z, d, rf)}, "status after write");
      $display("flag block %0d done", b);
    end
    bus(1'b0, 32'h00000010, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    g1 <= '0;
    g0 <= '0;
    crc <= '0;
    bus(1'b1, `CSF_THRESH_ADDR, 32'h00000008, rd);
    thr = 6'h08;
    irq_step(32'h00000001);
    irq_step(32'h00000000);
    $display("interrupt test done");
    complete_run();
  end
endmodule
